/* File: hw/smart_battery_charge_control.sv */
// Smart battery charger control: SMBus slave, command pairing, charge gating, alert and PWM watchdog.
`timescale 1ns/10ps
module smart_battery_charge_control #(
  parameter logic [32:0] WINDOW_CYCLES = 33'(charge_ctl_pkg::CMD_WINDOW_CYC)
) (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_oe,
  input  wire logic [2:0]  sense_code,
  input  wire logic [15:0] i_limit,
  input  wire logic [15:0] v_limit,
  input  wire logic        divider_in,
  input  wire logic        charge_enable_line_in,
  output logic             charge_enable_line_oe,
  input  wire logic        top_gate_drive_in,
  input  wire logic        ov_in,
  input  wire logic        vdd_fail,
  output logic             alert_oe,
  output logic             top_off,
  output logic [9:0]       i_dac,
  output logic [10:0]      v_dac,
  output logic             adapter_present_flag
);

  charge_ctl_pkg::ctl_t  st_r;
  charge_ctl_pkg::ctl_t  st_nxt;
  charge_ctl_pkg::pins_t pins;
  logic [7:0]            rx_sh_r;
  logic                  sda_oe_scl_r;
  logic                  scl_rise;
  logic                  start_c;
  logic                  stop_c;
  logic [15:0]           w_val;
  logic [15:0]           status_w;
  logic                  ac;
  logic                  bat;
  logic                  hot;
  logic                  pfail;

  // The shift register lives on the bus clock itself. The control side reads it
  // only after a synchronised rising edge, while SCL is still high and the bits
  // cannot move, so the word is stable when it crosses.
  always_ff @(posedge scl) begin
    rx_sh_r <= {rx_sh_r[6:0], sda_in};
  end

  // The drive request is set by the control side during SCL high, long before
  // the falling edge that launches it.
  always_ff @(negedge scl) begin
    sda_oe_scl_r <= st_r.drive;
  end

  // Gating by the transfer-live flag keeps the pin released during reset and
  // after a Stop, when no further falling edge may arrive.
  assign sda_oe = sda_oe_scl_r & st_r.live;

  assign pins = '{scl: scl, sda: sda_in, divider: divider_in, charge_enable_line: charge_enable_line_in,
                  top_gate_drive: top_gate_drive_in, ov: ov_in, vdd_fail: vdd_fail};

  assign scl_rise = st_r.s2.scl & ~st_r.scl_d;
  assign start_c  = st_r.s2.scl & st_r.scl_d & st_r.sda_d & ~st_r.s2.sda;
  assign stop_c   = st_r.s2.scl & st_r.scl_d & ~st_r.sda_d & st_r.s2.sda;
  assign w_val    = {rx_sh_r, st_r.lo};

  assign ac    = st_r.s2.divider;
  assign bat   = sense_code != charge_ctl_pkg::SENSE_ABSENT;
  assign hot   = sense_code == charge_ctl_pkg::SENSE_HOT;
  assign pfail = (~st_r.s2.charge_enable_line & st_r.en) | ~ac;

  assign status_w = {ac, bat, pfail, st_r.alarm,
                     sense_code == charge_ctl_pkg::SENSE_UNDER, hot,
                     sense_code == charge_ctl_pkg::SENSE_COLD, ~bat,
                     st_r.cur_or, st_r.vol_or, charge_ctl_pkg::STATUS_FIXED,
                     st_r.hold};

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1    = pins;
    st_nxt.s2    = st_r.s1;
    st_nxt.scl_d = st_r.s2.scl;
    st_nxt.sda_d = st_r.s2.sda;

    // Bus protocol engine.
    if (stop_c) begin
      st_nxt.bs    = charge_ctl_pkg::B_IDLE;
      st_nxt.drive = 1'b0;
      st_nxt.live  = 1'b0;
    end else if (start_c) begin
      st_nxt.bs    = charge_ctl_pkg::B_ADDR;
      st_nxt.cnt   = 4'h0;
      st_nxt.drive = 1'b0;
      st_nxt.live  = 1'b1;
    end else if (scl_rise && st_r.bs != charge_ctl_pkg::B_IDLE) begin
      st_nxt.cnt = st_r.cnt + 4'h1;
      if (st_r.cnt == 4'h7) begin
        st_nxt.drive = 1'b1;
        case (st_r.bs)
          charge_ctl_pkg::B_ADDR: begin
            st_nxt.first     = 1'b1;
            st_nxt.rd_status = 1'b0;
            if (rx_sh_r[7:1] == charge_ctl_pkg::DEV_ADDR && !rx_sh_r[0]) begin
              st_nxt.bs = charge_ctl_pkg::B_CMD;
            end else if (rx_sh_r[7:1] == charge_ctl_pkg::DEV_ADDR &&
                         st_r.cmd == charge_ctl_pkg::CMD_SPEC_INFO) begin
              st_nxt.bs   = charge_ctl_pkg::B_RLO;
              st_nxt.txb  = charge_ctl_pkg::SPEC_REPLY[7:0];
              st_nxt.txhi = charge_ctl_pkg::SPEC_REPLY[15:8];
            end else if (rx_sh_r[7:1] == charge_ctl_pkg::DEV_ADDR &&
                         st_r.cmd == charge_ctl_pkg::CMD_STATUS) begin
              st_nxt.bs        = charge_ctl_pkg::B_RLO;
              st_nxt.txb       = status_w[7:0];
              st_nxt.txhi      = status_w[15:8];
              st_nxt.rd_status = 1'b1;
            end else if (rx_sh_r == {charge_ctl_pkg::ALERT_RESP_ADDR, 1'b1} && st_r.alert) begin
              st_nxt.bs  = charge_ctl_pkg::B_ARA;
              st_nxt.txb = {charge_ctl_pkg::DEV_ADDR, 1'b0};
            end else begin
              // Reads of mode control, charging current, charging voltage, alarm and unknown codes are not answered.
              st_nxt.bs    = charge_ctl_pkg::B_SKIP;
              st_nxt.drive = 1'b0;
            end
          end
          charge_ctl_pkg::B_CMD: begin
            st_nxt.cmd = rx_sh_r;
            st_nxt.bs  = charge_ctl_pkg::B_WLO;
          end
          charge_ctl_pkg::B_WLO: begin
            st_nxt.lo = rx_sh_r;
            st_nxt.bs = charge_ctl_pkg::B_WHI;
          end
          charge_ctl_pkg::B_WHI: begin
            st_nxt.bs = charge_ctl_pkg::B_SKIP;
            case (st_r.cmd)
              charge_ctl_pkg::CMD_MODE: begin
                // Polling request is a don't-care on write.
                st_nxt.hold = w_val[charge_ctl_pkg::MODE_HOLD_BIT];
                if (w_val[charge_ctl_pkg::MODE_POR_BIT]) begin
                  st_nxt.hold      = 1'b0;
                  st_nxt.cmd_valid = 1'b0;
                  st_nxt.got_i     = 1'b0;
                  st_nxt.got_v     = 1'b0;
                end
                if (w_val[charge_ctl_pkg::MODE_ZERO_BIT]) begin
                  st_nxt.cur_set = 16'h0000;
                  st_nxt.vol_set = 16'h0000;
                end
              end
              charge_ctl_pkg::CMD_CURRENT: begin
                st_nxt.cur_or   = w_val > i_limit;
                st_nxt.cur_pend = (w_val > i_limit) ? i_limit : w_val;
                st_nxt.got_i    = 1'b1;
              end
              charge_ctl_pkg::CMD_VOLTAGE: begin
                st_nxt.vol_or   = w_val > v_limit;
                st_nxt.vol_pend = (w_val > v_limit) ? v_limit : w_val;
                st_nxt.got_v    = 1'b1;
              end
              charge_ctl_pkg::CMD_ALARM: begin
                st_nxt.alarm = |w_val[15:12];
              end
              default: begin
                st_nxt.bs = charge_ctl_pkg::B_SKIP;
              end
            endcase
            if (!st_r.got_i && !st_r.got_v && !st_r.cmd_valid &&
                (st_r.cmd == charge_ctl_pkg::CMD_CURRENT || st_r.cmd == charge_ctl_pkg::CMD_VOLTAGE)) begin
              st_nxt.win = 33'h0;
            end
          end
          charge_ctl_pkg::B_RLO, charge_ctl_pkg::B_RHI, charge_ctl_pkg::B_ARA: begin
            st_nxt.drive = 1'b0;
          end
          default: begin
            st_nxt.drive = 1'b0;
          end
        endcase
      end else if (st_r.cnt == 4'h8) begin
        st_nxt.cnt   = 4'h0;
        st_nxt.drive = 1'b0;
        st_nxt.first = 1'b0;
        case (st_r.bs)
          charge_ctl_pkg::B_RLO: begin
            if (st_r.first) begin
              st_nxt.drive = ~st_r.txb[7];
            end else if (!rx_sh_r[0]) begin
              st_nxt.bs    = charge_ctl_pkg::B_RHI;
              st_nxt.txb   = st_r.txhi;
              st_nxt.drive = ~st_r.txhi[7];
            end else begin
              st_nxt.bs = charge_ctl_pkg::B_SKIP;
            end
          end
          charge_ctl_pkg::B_ARA: begin
            if (st_r.first) begin
              st_nxt.drive = ~st_r.txb[7];
            end else begin
              st_nxt.alert = 1'b0;
              st_nxt.bs    = charge_ctl_pkg::B_SKIP;
            end
          end
          charge_ctl_pkg::B_RHI: begin
            if (st_r.rd_status) begin
              st_nxt.alert = 1'b0;
            end
            st_nxt.bs = charge_ctl_pkg::B_SKIP;
          end
          default: begin
            st_nxt.drive = 1'b0;
          end
        endcase
      end else if (st_r.bs == charge_ctl_pkg::B_RLO || st_r.bs == charge_ctl_pkg::B_RHI ||
                   st_r.bs == charge_ctl_pkg::B_ARA) begin
        st_nxt.drive = ~st_r.txb[3'(4'h6 - st_r.cnt)];
      end else begin
        st_nxt.drive = 1'b0;
      end
    end

    // Command pairing and window.
    if (st_nxt.got_i && st_nxt.got_v) begin
      st_nxt.cur_set   = st_nxt.cur_pend;
      st_nxt.vol_set   = st_nxt.vol_pend;
      st_nxt.cmd_valid = 1'b1;
      st_nxt.got_i     = 1'b0;
      st_nxt.got_v     = 1'b0;
      st_nxt.win       = 33'h0;
    end else if (st_r.win >= WINDOW_CYCLES - 33'h1) begin
      // Stale commands fall back to no commands at all.
      st_nxt.win       = 33'h0;
      st_nxt.got_i     = 1'b0;
      st_nxt.got_v     = 1'b0;
      st_nxt.cmd_valid = 1'b0;
      if (sense_code == charge_ctl_pkg::SENSE_COLD && !st_r.cmd_valid) begin
        st_nxt.wake_done = 1'b1;
      end
    end else begin
      st_nxt.win = st_r.win + 33'h1;
    end

    // Status tracking and hold release.
    st_nxt.ac_d    = ac;
    st_nxt.bat_d   = bat;
    st_nxt.alarm_d = st_r.alarm;
    st_nxt.vf_d    = st_r.s2.vdd_fail;
    if ((bat && !st_r.bat_d) || (ac && !st_r.ac_d)) begin
      st_nxt.hold = 1'b0;
    end
    if (!bat || (ac && !st_r.ac_d)) begin
      st_nxt.wake_done = 1'b0;
    end
    // A change in the same cycle as a clearing read still leaves the alert set.
    if ((ac != st_r.ac_d) || (bat != st_r.bat_d) || (st_r.alarm != st_r.alarm_d) ||
        (st_r.s2.vdd_fail && !st_r.vf_d)) begin
      st_nxt.alert = 1'b1;
    end

    // Charge gating; the hold bit leaves stored setpoints untouched.
    st_nxt.en = bat && !hot && ac && !st_nxt.hold && !st_nxt.alarm &&
                (st_nxt.cmd_valid || !st_nxt.wake_done);
    if (!st_nxt.en) begin
      st_nxt.i_dac = 10'h000;
      st_nxt.v_dac = 11'h000;
    end else if (st_nxt.cmd_valid) begin
      st_nxt.i_dac = 10'(st_nxt.cur_set >> charge_ctl_pkg::DAC_SHIFT);
      st_nxt.v_dac = 11'(st_nxt.vol_set >> charge_ctl_pkg::DAC_SHIFT);
    end else begin
      st_nxt.i_dac = 10'(charge_ctl_pkg::WAKE_CURRENT_MA >> charge_ctl_pkg::DAC_SHIFT);
      st_nxt.v_dac = 11'(v_limit >> charge_ctl_pkg::DAC_SHIFT);
    end

    // Top-gate watchdog and overvoltage hold-off.
    st_nxt.top_gate_drive_d = st_r.s2.top_gate_drive;
    if (st_r.s2.top_gate_drive != st_r.top_gate_drive_d) begin
      st_nxt.wd_cnt = 10'h000;
    end else if (st_r.wd_off != 4'h0) begin
      st_nxt.wd_off = st_r.wd_off - 4'h1;
    end else if (st_r.wd_cnt == 10'(charge_ctl_pkg::WDOG_IDLE_CYC)) begin
      st_nxt.wd_off = 4'(charge_ctl_pkg::WDOG_OFF_CYC);
      st_nxt.wd_cnt = 10'h000;
    end else begin
      st_nxt.wd_cnt = st_r.wd_cnt + 10'h001;
    end
    st_nxt.top_off = (st_nxt.wd_off != 4'h0) || st_r.s2.ov;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign charge_enable_line_oe             = ~st_r.en;
  assign alert_oe             = st_r.alert;
  assign top_off              = st_r.top_off;
  assign i_dac                = st_r.i_dac;
  assign v_dac                = st_r.v_dac;
  assign adapter_present_flag = st_r.s2.divider;

endmodule : smart_battery_charge_control

/* File: pkg/charge_ctl_pkg.sv */
// Constants and types shared by the smart battery charge control block.
package charge_ctl_pkg;

  localparam logic [6:0]  DEV_ADDR        = 7'h09;
  localparam logic [6:0]  ALERT_RESP_ADDR = 7'h0C;

  localparam logic [7:0]  CMD_SPEC_INFO   = 8'h11;
  localparam logic [7:0]  CMD_MODE        = 8'h12;
  localparam logic [7:0]  CMD_STATUS      = 8'h13;
  localparam logic [7:0]  CMD_CURRENT     = 8'h14;
  localparam logic [7:0]  CMD_VOLTAGE     = 8'h15;
  localparam logic [7:0]  CMD_ALARM       = 8'h16;

  localparam logic [15:0] SPEC_REPLY      = 16'h0002;
  localparam int          MODE_HOLD_BIT   = 0;
  localparam int          MODE_POLL_BIT   = 1;
  localparam int          MODE_POR_BIT    = 2;
  localparam int          MODE_ZERO_BIT   = 3;
  localparam logic [4:0]  STATUS_FIXED    = 5'h08;

  localparam logic [2:0]  SENSE_ABSENT    = 3'h0;
  localparam logic [2:0]  SENSE_HOT       = 3'h1;
  localparam logic [2:0]  SENSE_COLD      = 3'h2;
  localparam logic [2:0]  SENSE_UNDER     = 3'h3;
  localparam logic [2:0]  SENSE_IDEAL     = 3'h4;

  localparam logic [15:0] WAKE_CURRENT_MA = 16'h0050;
  localparam int          DAC_SHIFT       = 4;

  localparam longint unsigned MCLK_HZ        = 25000000;
  localparam longint unsigned CMD_WINDOW_S   = 175;
  localparam longint unsigned CMD_WINDOW_CYC = CMD_WINDOW_S * MCLK_HZ;
  localparam int          MCLK_NS         = 40;
  localparam int          WDOG_IDLE_NS    = 40000;
  localparam int          WDOG_OFF_NS     = 400;
  localparam int          WDOG_IDLE_CYC   = WDOG_IDLE_NS / MCLK_NS;
  localparam int          WDOG_OFF_CYC    = WDOG_OFF_NS / MCLK_NS;

  typedef struct packed {
    logic scl;
    logic sda;
    logic divider;
    logic charge_enable_line;
    logic top_gate_drive;
    logic ov;
    logic vdd_fail;
  } pins_t;

  typedef enum logic [3:0] {
    B_IDLE, B_ADDR, B_CMD, B_WLO, B_WHI, B_RLO, B_RHI, B_ARA, B_SKIP
  } bus_state_t;

  typedef struct packed {
    pins_t       s1;
    pins_t       s2;
    logic        scl_d;
    logic        sda_d;
    bus_state_t  bs;
    logic [3:0]  cnt;
    logic        first;
    logic        drive;
    logic        live;
    logic [7:0]  cmd;
    logic [7:0]  lo;
    logic [7:0]  txb;
    logic [7:0]  txhi;
    logic        rd_status;
    logic [15:0] cur_pend;
    logic [15:0] vol_pend;
    logic        got_i;
    logic        got_v;
    logic [15:0] cur_set;
    logic [15:0] vol_set;
    logic [32:0] win;
    logic        cmd_valid;
    logic        wake_done;
    logic        cur_or;
    logic        vol_or;
    logic        hold;
    logic        alarm;
    logic        ac_d;
    logic        bat_d;
    logic        alarm_d;
    logic        vf_d;
    logic        alert;
    logic [9:0]  wd_cnt;
    logic [3:0]  wd_off;
    logic        top_gate_drive_d;
    logic        top_off;
    logic        en;
    logic [9:0]  i_dac;
    logic [10:0] v_dac;
  } ctl_t;

endpackage : charge_ctl_pkg

/* File: test/smbus_host.sv */
// SMBus host model: a bit-level master on its own 125 ns clock; SCL stands high between frames.
`timescale 1ns/10ps
module smbus_host (
  output logic      scl,
  output logic      sda_oe,
  input  wire logic sda
);
  logic lclk;
  initial begin
    lclk   = 1'b0;
    scl    = 1'b1;
    sda_oe = 1'b0;
    #17;
    forever #62.5 lclk = ~lclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
    #1;
  endtask : tick
  // Data moves one tick after SCL falls, so the device's hold time is kept.
  task automatic bit_io(input logic oe, output logic v);
    sda_oe = oe;
    tick(2);
    scl = 1'b1;
    tick(3);
    v = sda;
    scl = 1'b0;
    tick(1);
  endtask : bit_io
  task automatic start_c();
    sda_oe = 1'b0;
    tick(1);
    scl = 1'b1;
    tick(2);
    sda_oe = 1'b1;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask : start_c
  task automatic stop_c();
    sda_oe = 1'b1;
    tick(1);
    scl = 1'b1;
    tick(2);
    sda_oe = 1'b0;
    tick(2);
  endtask : stop_c
  task automatic byte_w(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~b[i], v);
    end
    bit_io(1'b0, v);
    ack = ~v;
  endtask : byte_w
  task automatic byte_r(input logic nack, output logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b0, v);
      b = {b[6:0], v};
    end
    bit_io(~nack, v);
  endtask : byte_r
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
    logic [3:0] a;
    start_c();
    byte_w({charge_ctl_pkg::DEV_ADDR, 1'b0}, a[0]);
    byte_w(cmd, a[1]);
    byte_w(d[7:0], a[2]);
    byte_w(d[15:8], a[3]);
    stop_c();
    ok = &a;
  endtask : write_word
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
    logic [2:0] a;
    d = 16'hFFFF;
    start_c();
    byte_w({charge_ctl_pkg::DEV_ADDR, 1'b0}, a[0]);
    byte_w(cmd, a[1]);
    start_c();
    byte_w({charge_ctl_pkg::DEV_ADDR, 1'b1}, a[2]);
    if (a[2]) begin
      byte_r(1'b0, d[7:0]);
      byte_r(1'b1, d[15:8]);
    end
    stop_c();
    ok = &a;
  endtask : read_word
  // Alert response: the device returns its own address byte; the host NACKs it.
  task automatic ara(output logic [7:0] b, output logic ok);
    start_c();
    byte_w({charge_ctl_pkg::ALERT_RESP_ADDR, 1'b1}, ok);
    byte_r(1'b1, b);
    stop_c();
  endtask : ara
endmodule : smbus_host

/* File: test/charge_ctl_props.sv */
// Concurrent checks on the charge control block's ports.
`timescale 1ns/10ps
module charge_ctl_props #(
  parameter logic [32:0] WINDOW_CYCLES = 33'h0_0000_0001
) (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        scl,
  input wire logic        sda_oe,
  input wire logic [2:0]  sense_code,
  input wire logic [15:0] i_limit,
  input wire logic [15:0] v_limit,
  input wire logic        divider_in,
  input wire logic        charge_enable_line_oe,
  input wire logic        top_gate_drive_in,
  input wire logic        ov_in,
  input wire logic        alert_oe,
  input wire logic        top_off,
  input wire logic [9:0]  i_dac,
  input wire logic [10:0] v_dac
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [10:0] idle_r;
  logic        tg_r;
  always_ff @(posedge mclk) begin
    tg_r   <= top_gate_drive_in;
    idle_r <= (!rstn || top_gate_drive_in != tg_r) ? 11'h000 : idle_r + {10'h000, idle_r != 11'h7FF};
  end
  sequence wdog_pulse_s;
    top_off [*8] ##1 top_off [*2];
  endsequence
  sequence div_settled_s;
    $changed(divider_in) ##1 $stable(divider_in) [*6];
  endsequence
  AST_ABSENT_OFF: assert property ((sense_code == charge_ctl_pkg::SENSE_ABSENT) [*3] |-> charge_enable_line_oe)
    else $error("charging enabled with no battery");
  AST_HOT_OFF: assert property ((sense_code == charge_ctl_pkg::SENSE_HOT) [*3] |-> charge_enable_line_oe)
    else $error("charging enabled while too hot");
  AST_DIV_OFF: assert property (!divider_in [*4] |-> charge_enable_line_oe)
    else $error("charging enabled with supply divider low");
  AST_WDOG_LEN: assert property ($rose(top_off) && !ov_in |-> wdog_pulse_s)
    else $error("watchdog off pulse too short");
  AST_WDOG_IDLE: assert property ($rose(top_off) && !ov_in |-> idle_r > 11'h3E3)
    else $error("watchdog fired while top gate was switching");
  AST_OV_HOLD: assert property (ov_in [*4] |-> top_off)
    else $error("top switch not held off in overvoltage");
  AST_ALERT_RISE: assert property (div_settled_s |-> alert_oe)
    else $error("alert not raised on adapter change");
  AST_SDA_FALL: assert property ($changed(sda_oe) |-> !scl)
    else $error("data drive changed while clock high");
  AST_I_LIMIT: assert property ({6'h00, i_dac} <= (i_limit >> 4))
    else $error("current code above limit");
  AST_V_LIMIT: assert property ({5'h00, v_dac} <= (v_limit >> 4))
    else $error("voltage code above limit");
endmodule : charge_ctl_props

bind smart_battery_charge_control charge_ctl_props #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_props (
  .mclk(mclk), .rstn(rstn), .scl(scl), .sda_oe(sda_oe), .sense_code(sense_code), .i_limit(i_limit),
  .v_limit(v_limit), .divider_in(divider_in), .charge_enable_line_oe(charge_enable_line_oe), .top_gate_drive_in(top_gate_drive_in), .ov_in(ov_in),
  .alert_oe(alert_oe), .top_off(top_off), .i_dac(i_dac), .v_dac(v_dac));

/* File: test/tb.sv */
// Self-checking testbench for the charge control block driven through the SMBus host model.
`timescale 1ns/10ps
module tb;
  logic        mclk;
  logic        rstn;
  logic        scl;
  logic        host_oe;
  logic        sda_oe;
  wire logic   sda;
  logic [2:0]  sense_code;
  logic        divider_in;
  logic        charge_enable_line_oe;
  logic        top_gate_drive_in;
  logic        tg_run;
  logic        ov_in;
  logic        alert_oe;
  logic        top_off;
  logic [9:0]  i_dac;
  logic [10:0] v_dac;
  logic [15:0] s;
  logic        ext_pull;
  logic        vdd_in;
  logic        acp;
  logic [7:0]  ab;
  int          fail_count;
  int          cmp_count;
  // Open-drain data line with pull-up; the window is shortened to 8000 cycles.
  assign sda = ~(host_oe | sda_oe);
  smart_battery_charge_control #(.WINDOW_CYCLES(33'h0_0000_1F40)) i_dut (
    .mclk(mclk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_oe(sda_oe), .sense_code(sense_code),
    .i_limit(16'h1000), .v_limit(16'h4000), .divider_in(divider_in), .charge_enable_line_in(~(charge_enable_line_oe | ext_pull)),
    .charge_enable_line_oe(charge_enable_line_oe), .top_gate_drive_in(top_gate_drive_in), .ov_in(ov_in), .vdd_fail(vdd_in), .alert_oe(alert_oe),
    .top_off(top_off), .i_dac(i_dac), .v_dac(v_dac), .adapter_present_flag(acp));
  smbus_host i_host (.scl(scl), .sda_oe(host_oe), .sda(sda));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chb(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask : chb
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    logic ok;
    i_host.write_word(cmd, d, ok);
    chb("write ack", 1'b1, ok);
    cyc(4);
  endtask : wr
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
    i_host.read_word(cmd, d, ok);
    cyc(4);
  endtask : rd
  task automatic t_spec();
    logic ok;
    chb("enable no battery", 1'b1, charge_enable_line_oe);
    rd(charge_ctl_pkg::CMD_SPEC_INFO, s, ok);
    chk("spec info", charge_ctl_pkg::SPEC_REPLY, s);
    rd(charge_ctl_pkg::CMD_MODE, s, ok);
    chb("mode read ack", 1'b0, ok);
  endtask : t_spec
  task automatic t_wake();
    logic ok;
    divider_in = 1'b1;
    sense_code = charge_ctl_pkg::SENSE_IDEAL;
    cyc(10);
    chb("wake enable", 1'b0, charge_enable_line_oe);
    chk("wake dac", charge_ctl_pkg::WAKE_CURRENT_MA >> charge_ctl_pkg::DAC_SHIFT, {6'h00, i_dac});
    chb("alert set", 1'b1, alert_oe);
    rd(charge_ctl_pkg::CMD_STATUS, s, ok);
    chb("status adapter", 1'b1, s[15]);
    chb("alert cleared", 1'b0, alert_oe);
    chb("adapter flag", 1'b1, acp);
    chk("wake v dac", 16'h4000 >> charge_ctl_pkg::DAC_SHIFT, {5'h00, v_dac});
    // Another party holds the enable line low while the device wants to charge.
    ext_pull = 1'b1;
    rd(charge_ctl_pkg::CMD_STATUS, s, ok);
    chb("status power fail", 1'b1, s[13]);
    ext_pull = 1'b0;
    vdd_in = 1'b1;
    cyc(4);
    vdd_in = 1'b0;
    cyc(4);
    chb("alert on supply fail", 1'b1, alert_oe);
    i_host.ara(ab, ok);
    cyc(4);
    chb("alert response ack", 1'b1, ok);
    chk("alert response", {8'h00, charge_ctl_pkg::DEV_ADDR, 1'b0}, {8'h00, ab});
    chb("alert after response", 1'b0, alert_oe);
  endtask : t_wake
  task automatic t_hot();
    sense_code = charge_ctl_pkg::SENSE_HOT;
    cyc(6);
    chb("enable hot", 1'b1, charge_enable_line_oe);
    sense_code = charge_ctl_pkg::SENSE_IDEAL;
    divider_in = 1'b0;
    cyc(8);
    chb("enable divider low", 1'b1, charge_enable_line_oe);
    chb("adapter flag low", 1'b0, acp);
    divider_in = 1'b1;
    cyc(8);
  endtask : t_hot
  task automatic t_pair();
    logic ok;
    wr(charge_ctl_pkg::CMD_CURRENT, 16'h0640);
    wr(charge_ctl_pkg::CMD_VOLTAGE, 16'h3000);
    chk("i dac", 16'h0064, {6'h00, i_dac});
    chk("v dac", 16'h0300, {5'h00, v_dac});
    chb("pair enable", 1'b0, charge_enable_line_oe);
    wr(charge_ctl_pkg::CMD_CURRENT, 16'h2000);
    wr(charge_ctl_pkg::CMD_VOLTAGE, 16'h5000);
    chk("i dac clipped", 16'h0100, {6'h00, i_dac});
    chk("v dac clipped", 16'h0400, {5'h00, v_dac});
    rd(charge_ctl_pkg::CMD_STATUS, s, ok);
    chk("overrange flags", 16'h0003, {14'h0000, s[7:6]});
  endtask : t_pair
  task automatic t_hold();
    logic ok;
    wr(charge_ctl_pkg::CMD_MODE, 16'h0003);
    chb("hold enable", 1'b1, charge_enable_line_oe);
    rd(charge_ctl_pkg::CMD_STATUS, s, ok);
    chb("status hold", 1'b1, s[0]);
    wr(charge_ctl_pkg::CMD_MODE, 16'h0002);
    chb("resume enable", 1'b0, charge_enable_line_oe);
    chk("kept i dac", 16'h0100, {6'h00, i_dac});
    wr(charge_ctl_pkg::CMD_MODE, 16'h0001);
    sense_code = charge_ctl_pkg::SENSE_ABSENT;
    cyc(10);
    sense_code = charge_ctl_pkg::SENSE_IDEAL;
    cyc(10);
    rd(charge_ctl_pkg::CMD_STATUS, s, ok);
    chb("hold after reinsert", 1'b0, s[0]);
  endtask : t_hold
  task automatic t_wdog();
    int n;
    tg_run = 1'b0;
    n = 0;
    while (!top_off && n < 1200) begin
      cyc(1);
      n++;
    end
    chb("watchdog fired", 1'b1, top_off);
    n = 0;
    while (top_off && n < 40) begin
      cyc(1);
      n++;
    end
    chk("off pulse cycles", 16'h000A, 16'(n));
    tg_run = 1'b1;
    ov_in = 1'b1;
    cyc(30);
    chb("ov hold", 1'b1, top_off);
    ov_in = 1'b0;
    cyc(6);
    chb("ov released", 1'b0, top_off);
  endtask : t_wdog
  task automatic t_expire();
    cyc(8200);
    chk("expired to wake", 16'h0005, {6'h00, i_dac});
    sense_code = charge_ctl_pkg::SENSE_COLD;
    cyc(8200);
    chb("cold wake ended", 1'b1, charge_enable_line_oe);
  endtask : t_expire
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    top_gate_drive_in = 1'b0;
    forever begin
      cyc(10);
      if (tg_run) begin
        top_gate_drive_in = ~top_gate_drive_in;
      end
    end
  end
  initial begin
    fail_count = 0;
    cmp_count = 0;
    rstn = 1'b0;
    sense_code = charge_ctl_pkg::SENSE_ABSENT;
    divider_in = 1'b0;
    ov_in = 1'b0;
    ext_pull = 1'b0;
    vdd_in = 1'b0;
    tg_run = 1'b1;
    cyc(6);
    rstn = 1'b1;
    cyc(8);
    t_spec();
    t_wake();
    t_hot();
    t_pair();
    t_hold();
    t_wdog();
    t_expire();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    test_done();
  end
endmodule : tb
